// ### bmmd_decoder.sv
`default_nettype none
module bmmd_decoder #(
	parameter int IMPL_ADDR_W    = bmmd_pkg::IMPL_ADDR_W,
	parameter bit NARROW_VARIANT = 1'b0
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [31:0]                 awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [31:0]                 araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	input  wire bmmd_pkg::bmmd_fetch_ctl_type fetch_ctl,
	output logic [IMPL_ADDR_W-1:0]           fetch_addr,
	output logic [12:0]                      pc,
	input  wire bmmd_pkg::bmmd_file_req_type file_req,
	output logic [7:0]                       file_rdata,
	output logic                             file_rvalid,
	input  wire logic                        flags_we,
	input  wire logic [2:0]                  flags,
	output logic [7:0]                       status_flags,
	output logic [7:0]                       int_ctrl,
	output logic                             periph_sel,
	output logic                             periph_we,
	output logic [8:0]                       periph_addr,
	output logic [7:0]                       periph_wdata,
	input  wire logic [7:0]                  periph_rdata
);
	if (IMPL_ADDR_W < 1 || IMPL_ADDR_W > bmmd_pkg::PC_W) begin : g_chk
		$error("IMPL_ADDR_W must lie between 1 and 13");
	end

	bmmd_pkg::bmmd_axi_state_type axi_state;
	logic [7:0] ram [0:511];
	logic [7:0] indirect_pointer;
	logic [4:0] pc_high_latch;
	logic [8:0] axi_addr;
	logic [7:0] axi_wdata;
	logic       axi_wr_lane;
	logic       acc_valid;
	logic       acc_we;
	logic [8:0] acc_addr;
	logic [7:0] acc_wdata;
	logic       axi_go;
	logic       is_ind;
	logic [8:0] eff_addr;
	logic [6:0] eff_off;
	logic       ind_loop;
	logic       psp_hit;
	logic       core_hit;
	logic       ram_hit;
	logic [8:0] ram_index;
	logic [7:0] rd_value;
	logic       wr;
	logic       aw_take;
	logic       ar_take;
	logic [9:0] aw_index;
	logic [9:0] ar_index;

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc <= bmmd_pkg::RESET_VECTOR;
		end else if (fetch_ctl.int_take) begin
			pc <= bmmd_pkg::INT_VECTOR;
		end else if (wr && core_hit && eff_off == bmmd_pkg::OFF_PC_LOW) begin
			pc <= {pc_high_latch, acc_wdata};
		end else if (fetch_ctl.jump) begin
			pc <= {pc_high_latch[4:3], fetch_ctl.jump_target};
		end else if (fetch_ctl.fetch_next) begin
			pc <= pc + 13'h0001;
		end
	end

	// Own bus, never shared with data access
	assign fetch_addr = pc[IMPL_ADDR_W-1:0];

	// ----------------------------------------------------------------
	// Access arbitration, core datapath first
	// ----------------------------------------------------------------
	always_comb begin
		acc_valid = 1'b0;
		acc_we = 1'b0;
		acc_addr = 9'h000;
		acc_wdata = 8'h00;
		if (file_req.valid) begin
			acc_valid = 1'b1;
			acc_we = file_req.we;
			acc_addr = {status_flags[bmmd_pkg::BANK_HI:bmmd_pkg::BANK_LO],
				file_req.offset};
			acc_wdata = file_req.wdata;
		end else if (axi_state == bmmd_pkg::AX_WR) begin
			acc_valid = 1'b1;
			acc_we = axi_wr_lane;
			acc_addr = axi_addr;
			acc_wdata = axi_wdata;
		end else if (axi_state == bmmd_pkg::AX_RD) begin
			acc_valid = 1'b1;
			acc_addr = axi_addr;
		end
	end

	assign axi_go = !file_req.valid &&
		(axi_state == bmmd_pkg::AX_WR || axi_state == bmmd_pkg::AX_RD);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign is_ind = acc_addr[6:0] == bmmd_pkg::OFF_INDIRECT;
	assign eff_addr = is_ind ?
		{status_flags[bmmd_pkg::STATUS_IND_BANK], indirect_pointer} :
		acc_addr;
	assign eff_off = eff_addr[6:0];
	assign ind_loop = eff_off == bmmd_pkg::OFF_INDIRECT;
	assign psp_hit = NARROW_VARIANT &&
		(eff_addr == bmmd_pkg::PSP_DATA_ADDR ||
		eff_addr == bmmd_pkg::PSP_CTRL_ADDR ||
		eff_addr == bmmd_pkg::PSP_DDIR_ADDR ||
		eff_addr == bmmd_pkg::PSP_DCTL_ADDR);
	assign core_hit = eff_off == bmmd_pkg::OFF_PC_LOW ||
		eff_off == bmmd_pkg::OFF_STATUS ||
		eff_off == bmmd_pkg::OFF_POINTER ||
		eff_off == bmmd_pkg::OFF_PC_HIGH ||
		eff_off == bmmd_pkg::OFF_INT_CTRL;
	assign ram_hit = eff_off >= bmmd_pkg::OFF_RAM_BASE;
	assign ram_index = (eff_off >= bmmd_pkg::OFF_SHARED_RAM) ?
		{2'b00, eff_off} : eff_addr;
	assign wr = acc_valid && acc_we && !ind_loop;

	always_comb begin
		rd_value = 8'h00;
		if (ind_loop || psp_hit) begin
			rd_value = 8'h00;
		end else if (ram_hit) begin
			rd_value = ram[ram_index];
		end else if (eff_off == bmmd_pkg::OFF_PC_LOW) begin
			rd_value = pc[7:0];
		end else if (eff_off == bmmd_pkg::OFF_STATUS) begin
			rd_value = status_flags;
		end else if (eff_off == bmmd_pkg::OFF_POINTER) begin
			rd_value = indirect_pointer;
		end else if (eff_off == bmmd_pkg::OFF_PC_HIGH) begin
			rd_value = {3'b000, pc_high_latch};
		end else if (eff_off == bmmd_pkg::OFF_INT_CTRL) begin
			rd_value = int_ctrl;
		end else begin
			rd_value = periph_rdata;
		end
	end

	// Peripheral locations outside this block
	assign periph_sel = acc_valid && !ind_loop && !psp_hit && !ram_hit &&
		!core_hit;
	assign periph_we = periph_sel && acc_we;
	assign periph_addr = eff_addr;
	assign periph_wdata = acc_wdata;

	// ----------------------------------------------------------------
	// Register file storage
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (wr && ram_hit && !psp_hit) begin
			ram[ram_index] <= acc_wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_flags <= bmmd_pkg::STATUS_RESET;
		end else if (wr && eff_off == bmmd_pkg::OFF_STATUS) begin
			status_flags <= (acc_wdata & bmmd_pkg::STATUS_WR_MASK) |
				(status_flags & ~bmmd_pkg::STATUS_WR_MASK);
		end else if (flags_we) begin
			status_flags[2:0] <= flags;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			indirect_pointer <= bmmd_pkg::POINTER_RESET;
		end else if (wr && eff_off == bmmd_pkg::OFF_POINTER) begin
			indirect_pointer <= acc_wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_high_latch <= bmmd_pkg::PC_HIGH_RESET;
		end else if (wr && eff_off == bmmd_pkg::OFF_PC_HIGH) begin
			pc_high_latch <= acc_wdata[4:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_ctrl <= bmmd_pkg::INT_CTRL_RESET;
		end else if (wr && eff_off == bmmd_pkg::OFF_INT_CTRL) begin
			int_ctrl <= acc_wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			file_rdata <= 8'h00;
			file_rvalid <= 1'b0;
		end else begin
			file_rvalid <= file_req.valid && !file_req.we;
			if (file_req.valid && !file_req.we) begin
				file_rdata <= rd_value;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign aw_index = awaddr[11:2];
	assign ar_index = araddr[11:2];
	assign aw_take = axi_state == bmmd_pkg::AX_IDLE && awvalid && wvalid;
	assign ar_take = axi_state == bmmd_pkg::AX_IDLE && arvalid && !aw_take;
	assign awready = aw_take;
	assign wready = aw_take;
	assign arready = ar_take;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			axi_state <= bmmd_pkg::AX_IDLE;
			axi_addr <= 9'h000;
			axi_wdata <= 8'h00;
			axi_wr_lane <= 1'b0;
			bvalid <= 1'b0;
			bresp <= bmmd_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= bmmd_pkg::RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else begin
			case (axi_state)
			bmmd_pkg::AX_IDLE: begin
				if (aw_take) begin
					axi_addr <= aw_index[8:0];
					axi_wdata <= wdata[7:0];
					axi_wr_lane <= wstrb[0];
					if (awaddr[31:12] == 20'h00000 && !aw_index[9]) begin
						axi_state <= bmmd_pkg::AX_WR;
					end else begin
						bresp <= bmmd_pkg::RESP_SLVERR;
						bvalid <= 1'b1;
						axi_state <= bmmd_pkg::AX_BRESP;
					end
				end else if (ar_take) begin
					axi_addr <= ar_index[8:0];
					if (araddr[31:12] == 20'h00000 && !ar_index[9]) begin
						axi_state <= bmmd_pkg::AX_RD;
					end else begin
						rvalid <= 1'b1;
						axi_state <= bmmd_pkg::AX_RRESP;
						if (araddr[31:12] == 20'h00000 &&
							ar_index == bmmd_pkg::AXI_PC_INDEX) begin
							rdata <= {19'h00000, pc};
							rresp <= bmmd_pkg::RESP_OKAY;
						end else begin
							rdata <= 32'h0000_0000;
							rresp <= bmmd_pkg::RESP_SLVERR;
						end
					end
				end
			end
			bmmd_pkg::AX_WR: begin
				if (axi_go) begin
					bresp <= bmmd_pkg::RESP_OKAY;
					bvalid <= 1'b1;
					axi_state <= bmmd_pkg::AX_BRESP;
				end
			end
			bmmd_pkg::AX_BRESP: begin
				if (bready) begin
					bvalid <= 1'b0;
					axi_state <= bmmd_pkg::AX_IDLE;
				end
			end
			bmmd_pkg::AX_RD: begin
				if (axi_go) begin
					rdata <= {24'h000000, rd_value};
					rresp <= bmmd_pkg::RESP_OKAY;
					rvalid <= 1'b1;
					axi_state <= bmmd_pkg::AX_RRESP;
				end
			end
			bmmd_pkg::AX_RRESP: begin
				if (rready) begin
					rvalid <= 1'b0;
					axi_state <= bmmd_pkg::AX_IDLE;
				end
			end
			default: begin
				axi_state <= bmmd_pkg::AX_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking assert_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	reset_vector_a: assert property (
		$past(!aresetn) |-> pc == 13'h0000)
		else $error("fetch did not start at zero after reset");

	int_vector_a: assert property (
		fetch_ctl.int_take |=> pc == 13'h0004)
		else $error("interrupt did not load vector four");

	fetch_wrap_a: assert property (
		pc >= bmmd_pkg::IMPL_SPAN && IMPL_ADDR_W == 12 |->
		fetch_addr == 12'(pc - bmmd_pkg::IMPL_SPAN))
		else $error("fetch above implemented range did not wrap");

	counter_step_a: assert property (
		fetch_ctl.fetch_next && !fetch_ctl.int_take && !fetch_ctl.jump &&
		!file_req.valid && !axi_go |=> pc == 13'($past(pc) + 13'h0001))
		else $error("program counter did not advance by one");

	bank_switch_a: assert property (
		file_req.valid && file_req.we && file_req.offset == 7'h03 |=>
		status_flags[6:5] == $past(file_req.wdata[6:5]))
		else $error("status write did not select the bank");

	indirect_read_a: assert property (
		file_req.valid && !file_req.we && file_req.offset == 7'h00 &&
		indirect_pointer[6:0] == 7'h03 |=> file_rdata == $past(status_flags))
		else $error("indirect read did not follow the pointer");

	latch_load_a: assert property (
		file_req.valid && file_req.we && file_req.offset == 7'h02 &&
		!fetch_ctl.int_take |=> pc[12:8] == $past(pc_high_latch))
		else $error("upper counter bits not taken from latch");

	absent_zero_a: assert property (
		acc_valid && psp_hit && !acc_we |-> !periph_sel ##1
		(!$past(file_req.valid) || file_rdata == 8'h00))
		else $error("absent location did not read zero");

	file_answer_a: assert property (
		file_req.valid && !file_req.we |=> file_rvalid ##1
		(!$past(file_req.valid) || $past(file_req.we) || file_rvalid))
		else $error("file read not answered in one cycle");

	write_resp_a: assert property (
		axi_state == bmmd_pkg::AX_WR && !file_req.valid |=> bvalid [*1])
		else $error("bus write not answered after access");

	indirect_cover: cover property (@(posedge aclk) disable iff (!aresetn)
		file_req.valid && file_req.offset == 7'h00);
	interrupt_cover: cover property (@(posedge aclk) disable iff (!aresetn)
		fetch_ctl.int_take);
	bus_read_cover: cover property (@(posedge aclk) disable iff (!aresetn)
		rvalid && rready && rresp == bmmd_pkg::RESP_OKAY);
endmodule // bmmd_decoder
`default_nettype wire

// ### bmmd_decoder_tb.sv
`default_nettype none
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("mismatch at %0t: got %h expected %h", $time, g, e); \
	end \
end
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module bmmd_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        aclk = 1'b0;
	logic        aresetn;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, file_rvalid, periph_sel;
	logic        periph_we;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [11:0] fetch_addr;
	logic [12:0] pc;
	logic [7:0]  file_rdata, status_flags, int_ctrl, periph_wdata;
	logic [8:0]  periph_addr;
	logic [16:0] periph_seen;
	logic [7:0]  ref_mem [512];
	integer      seed;
	int          fail_count = 0;
	int          total_checks = 0;
	wire logic [7:0] periph_rdata;
	wire logic [3:0] hs;
	bmmd_pkg::bmmd_file_req_type  file_req;
	bmmd_pkg::bmmd_fetch_ctl_type fetch_ctl;

	assign periph_rdata = periph_addr[7:0] ^ 8'h5a;
	assign hs = {rvalid, arready, bvalid, awready};

	always #10 aclk = ~aclk;

	// Last peripheral write seen at a clock edge
	always @(posedge aclk) begin
		if (periph_sel && periph_we) begin
			periph_seen <= {periph_addr, periph_wdata};
		end
	end

	bmmd_decoder #(.NARROW_VARIANT(1'b1)) bmmd_decoder_i (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.fetch_ctl(fetch_ctl), .fetch_addr(fetch_addr), .pc(pc),
		.file_req(file_req), .file_rdata(file_rdata),
		.file_rvalid(file_rvalid), .flags_we(1'b0), .flags(3'h0),
		.status_flags(status_flags), .int_ctrl(int_ctrl),
		.periph_sel(periph_sel), .periph_we(periph_we),
		.periph_addr(periph_addr), .periph_wdata(periph_wdata),
		.periph_rdata(periph_rdata)
	);

	bmmd_dp_model bmmd_dp_model_i (
		.aclk(aclk), .file_req(file_req), .fetch_ctl(fetch_ctl),
		.file_rdata(file_rdata), .file_rvalid(file_rvalid)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic wait_hi(input int k);
		int n;
		n = 0;
		@(negedge aclk);
		while (hs[k] !== 1'b1 && n < 50) begin
			@(negedge aclk);
			n++;
		end
		if (hs[k] !== 1'b1) begin
			fail_count++;
			$display("mismatch at %0t: handshake timeout", $time);
			wrap_up();
		end
	endtask

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] rs);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		wait_hi(0);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		wait_hi(1);
		rs = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		wait_hi(2);
		@(posedge aclk);
		arvalid <= 1'b0;
		wait_hi(3);
		d = rdata;
		rs = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	task automatic fop(input logic v, input logic we, input logic [6:0] o,
		input logic [7:0] d, input bmmd_pkg::bmmd_fetch_ctl_type c);
		bmmd_dp_model_i.op(v, we, o, d, c);
	endtask

	task automatic do_reset();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [1:0]  rs;
		logic [7:0]  d;
		logic [7:0]  st;
		int          a;
		seed = 32'ha74a6869;
		{awaddr, wdata, araddr} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'h1;
		aresetn = 1'b0;
		do_reset();
		`CHK(pc, bmmd_pkg::RESET_VECTOR);
		fop(1'b1, 1'b0, bmmd_pkg::OFF_STATUS, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, bmmd_pkg::STATUS_RESET);
		$display("reset test done");
		for (int b = 0; b < 4; b++) begin
			st = 8'h18 | 8'(b << 5);
			fop(1'b1, 1'b1, bmmd_pkg::OFF_STATUS, st, '0);
			`CHK(status_flags, st);
			d = 8'($random(seed));
			a = b * 128 + 32 + b;
			ref_mem[a] = d;
			fop(1'b1, 1'b1, 7'(32 + b), d, '0);
			axi_rd(32'(a * 4), r, rs);
			`CHK(r[7:0], ref_mem[a]);
			`CHK(rs, bmmd_pkg::RESP_OKAY);
			fop(1'b1, 1'b0, bmmd_pkg::OFF_STATUS, 8'h00, '0);
			`CHK(bmmd_dp_model_i.got, st);
		end
		d = 8'($random(seed));
		ref_mem[9'h07f] = d;
		fop(1'b1, 1'b1, 7'h7f, d, '0);
		axi_rd(32'h0000_01fc, r, rs);
		`CHK(r[7:0], ref_mem[9'h07f]);
		ref_mem[9'h1b0] = 8'hc3;
		axi_wr(32'h0000_06c0, 32'h0000_00c3, rs);
		fop(1'b1, 1'b0, 7'h30, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, ref_mem[9'h1b0]);
		$display("bank test done");
		fop(1'b1, 1'b1, bmmd_pkg::OFF_POINTER, 8'h22, '0);
		fop(1'b1, 1'b1, bmmd_pkg::OFF_STATUS, 8'h98, '0);
		d = 8'($random(seed));
		ref_mem[9'h122] = d;
		axi_wr(32'h0000_0488, {24'h000000, d}, rs);
		`CHK(rs, bmmd_pkg::RESP_OKAY);
		fop(1'b1, 1'b0, bmmd_pkg::OFF_INDIRECT, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, ref_mem[9'h122]);
		d = d ^ (8'($random(seed)) | 8'h01);
		ref_mem[9'h122] = d;
		fop(1'b1, 1'b1, bmmd_pkg::OFF_INDIRECT, d, '0);
		axi_rd(32'h0000_0488, r, rs);
		`CHK(r[7:0], ref_mem[9'h122]);
		$display("indirect test done");
		fop(1'b1, 1'b0, 7'h05, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, 8'h5f);
		fop(1'b1, 1'b0, 7'h08, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, 8'h00);
		fop(1'b1, 1'b1, bmmd_pkg::OFF_STATUS, 8'h38, '0);
		fop(1'b1, 1'b0, 7'h08, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, 8'h00);
		axi_rd(32'h0000_0024, r, rs);
		`CHK(r, 32'h0000_0000);
		$display("variant test done");
		fop(1'b1, 1'b1, bmmd_pkg::OFF_PC_HIGH, 8'h1f, '0);
		fop(1'b1, 1'b1, bmmd_pkg::OFF_PC_LOW, 8'hff, '0);
		`CHK(pc, 13'h1fff);
		`CHK(fetch_addr, 12'hfff);
		fop(1'b0, 1'b0, 7'h00, 8'h00, 14'h0001);
		`CHK(pc, 13'h0000);
		fop(1'b0, 1'b0, 7'h00, 8'h00, {1'b0, 1'b1, 11'h7fe, 1'b0});
		`CHK(fetch_addr, 12'hffe);
		axi_rd(32'h0000_0800, r, rs);
		`CHK(r, 32'h0000_1ffe);
		fop(1'b1, 1'b0, bmmd_pkg::OFF_PC_HIGH, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, 8'h1f);
		fop(1'b1, 1'b0, bmmd_pkg::OFF_POINTER, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, 8'h22);
		fop(1'b1, 1'b1, bmmd_pkg::OFF_POINTER, 8'h03, '0);
		fop(1'b1, 1'b0, bmmd_pkg::OFF_INDIRECT, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, 8'h38);
		fop(1'b1, 1'b1, bmmd_pkg::OFF_INT_CTRL, 8'ha5, '0);
		`CHK(int_ctrl, 8'ha5);
		fop(1'b1, 1'b1, 7'h06, 8'h3c, '0);
		`CHK(periph_seen, {9'h086, 8'h3c});
		fop(1'b1, 1'b0, bmmd_pkg::OFF_STATUS, 8'h00, 14'h2000);
		`CHK(pc, bmmd_pkg::INT_VECTOR);
		`CHK(bmmd_dp_model_i.got, 8'h38);
		$display("counter test done");
		axi_rd(32'h0000_0900, r, rs);
		`CHK(rs, bmmd_pkg::RESP_SLVERR);
		`CHK(r, 32'h0000_0000);
		axi_wr(32'h0000_0904, 32'h0000_005a, rs);
		`CHK(rs, bmmd_pkg::RESP_SLVERR);
		$display("bus error test done");
		do_reset();
		`CHK(pc, bmmd_pkg::RESET_VECTOR);
		fop(1'b1, 1'b0, bmmd_pkg::OFF_STATUS, 8'h00, '0);
		`CHK(bmmd_dp_model_i.got, bmmd_pkg::STATUS_RESET);
		$display("second reset test done");
		wrap_up();
	end
endmodule // bmmd_decoder_tb
`default_nettype wire

// ### bmmd_dp_model.sv
`default_nettype none
// ------------------------------------------------------------
// Datapath stand-in: fetch control and file port requests
// ------------------------------------------------------------
module bmmd_dp_model (
	input  wire logic                         aclk,
	output var  bmmd_pkg::bmmd_file_req_type  file_req,
	output var  bmmd_pkg::bmmd_fetch_ctl_type fetch_ctl,
	input  wire logic [7:0]                   file_rdata,
	input  wire logic                         file_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] got;

	initial begin
		file_req = '0;
		fetch_ctl = '0;
		got = 8'h00;
	end

	// One-cycle request; fetch and file share the cycle
	task automatic op(input logic v, input logic we, input logic [6:0] off,
		input logic [7:0] d, input bmmd_pkg::bmmd_fetch_ctl_type c);
		@(posedge aclk);
		file_req <= {v, we, off, d};
		fetch_ctl <= c;
		@(posedge aclk);
		file_req <= '0;
		fetch_ctl <= '0;
		@(negedge aclk);
		got = file_rvalid ? file_rdata : 8'hxx;
	endtask
endmodule // bmmd_dp_model
`default_nettype wire

// ### bmmd_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------
package bmmd_pkg;
	localparam int PC_W = 13;
	localparam int IMPL_ADDR_W = 12;
	localparam int FILE_ADDR_W = 9;
	localparam int OFFSET_W = 7;
	localparam int LATCH_W = 5;
	localparam int JUMP_W = 11;
	localparam logic [12:0] RESET_VECTOR = 13'h0000;
	localparam logic [12:0] INT_VECTOR = 13'h0004;
	localparam logic [12:0] IMPL_SPAN = 13'h1000;
	// In-bank offsets of the core registers and of the RAM areas
	localparam logic [6:0] OFF_INDIRECT = 7'h00;
	localparam logic [6:0] OFF_PC_LOW = 7'h02;
	localparam logic [6:0] OFF_STATUS = 7'h03;
	localparam logic [6:0] OFF_POINTER = 7'h04;
	localparam logic [6:0] OFF_PC_HIGH = 7'h0a;
	localparam logic [6:0] OFF_INT_CTRL = 7'h0b;
	localparam logic [6:0] OFF_RAM_BASE = 7'h20;
	localparam logic [6:0] OFF_SHARED_RAM = 7'h70;
	// Parallel slave port data and direction locations
	localparam logic [8:0] PSP_DATA_ADDR = 9'h008;
	localparam logic [8:0] PSP_CTRL_ADDR = 9'h009;
	localparam logic [8:0] PSP_DDIR_ADDR = 9'h088;
	localparam logic [8:0] PSP_DCTL_ADDR = 9'h089;
	// Status field positions and reset values
	localparam int STATUS_IND_BANK = 7;
	localparam int BANK_HI = 6;
	localparam int BANK_LO = 5;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] STATUS_WR_MASK = 8'he7;
	localparam logic [7:0] POINTER_RESET = 8'h00;
	localparam logic [4:0] PC_HIGH_RESET = 5'h00;
	localparam logic [7:0] INT_CTRL_RESET = 8'h00;
	// Bus map: word index of each location, byte address = 4 * index
	localparam logic [9:0] AXI_PC_INDEX = 10'h200;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       valid;
		logic       we;
		logic [6:0] offset;
		logic [7:0] wdata;
	} bmmd_file_req_type;

	typedef struct packed {
		logic       int_take;
		logic       jump;
		logic [10:0] jump_target;
		logic       fetch_next;
	} bmmd_fetch_ctl_type;

	typedef enum logic [4:0] {
		AX_IDLE  = 5'b00001,
		AX_WR    = 5'b00010,
		AX_BRESP = 5'b00100,
		AX_RD    = 5'b01000,
		AX_RRESP = 5'b10000
	} bmmd_axi_state_type;
endpackage
`default_nettype wire
